// ### hw/eic_pkg.sv
// Function
// - Upper two bits of extended priority two read zero, writes ignored.
// - Each priority bit except bit 2 (stored, drives no output): 0 selects low priority, 1 selects high priority.
// - Polarity bit 0 makes an input active low, 1 active high.
// - Edge select bit 1 gives edge detection, 0 gives level detection.
// - Input B pin comes from port 0 pin chosen by config bits 6:4.
// - Input A pin comes from port 0 pin chosen by config bits 2:0.
// - Pins are sampled without disturbing crossbar-assigned peripherals.
// - Pending flags for A and B sit in timer control bits 1 and 3.
// - Edge mode: flag set on active edge, cleared when CPU vectors.
// - Level mode: flag follows input, 1 while active, 0 while inactive.
package eic_pkg;
   localparam logic [7:0] EIC_ADDR_CONFIG = 8'he4;
   localparam logic [7:0] EIC_ADDR_PRIO2 = 8'hf7;
   localparam logic [7:0] EIC_ADDR_TIMER_CONTROL_REG = 8'h88;
   localparam logic [7:0] EIC_CONFIG_RESET = 8'h01;
   localparam logic [7:0] EIC_PRIO2_RESET = 8'h00;
   localparam logic [7:0] EIC_PRIO2_WMASK = 8'h3f;
   localparam int EIC_CH_A = 0;
   localparam int EIC_CH_B = 1;
   localparam int EIC_SEL_A_LSB = 0;
   localparam int EIC_POL_A_BIT = 3;
   localparam int EIC_SEL_B_LSB = 4;
   localparam int EIC_POL_B_BIT = 7;
   localparam int EIC_SEL_W = 3;
   localparam int EIC_EDGE_A_BIT = 0;
   localparam int EIC_PEND_A_BIT = 1;
   localparam int EIC_EDGE_B_BIT = 2;
   localparam int EIC_PEND_B_BIT = 3;
   localparam int EIC_PRIO_VBUS = 0;
   localparam int EIC_PRIO_UART1 = 1;
   localparam int EIC_PRIO_SMBUS1 = 3;
   localparam int EIC_PRIO_TIMER4 = 4;
   localparam int EIC_PRIO_TIMER5 = 5;
endpackage

// ### hw/eic_chan_if.sv
interface eic_chan_if;
   logic polarity;
   logic pinLevel;
   logic activeNow;
   logic edgeHit;
   modport ctrl (output polarity, output pinLevel, input activeNow, input edgeHit);
   modport det (input polarity, input pinLevel, output activeNow, output edgeHit);
endinterface

// ### hw/eic_detect.sv
module eic_detect (
   input wire logic core_clk,
   input wire logic reset_n,
   eic_chan_if.det chan
);
   logic prevActive_r;
   logic prevActive_nxt;

   // Active level is the pin matched against polarity
   always_comb begin
      chan.activeNow = (chan.pinLevel == chan.polarity);
      chan.edgeHit = chan.activeNow & ~prevActive_r;
      prevActive_nxt = chan.activeNow;
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         prevActive_r <= 1'b0;
      end else begin
         prevActive_r <= prevActive_nxt;
      end
   end
endmodule

// ### hw/eic_top.sv
module eic_top (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic [7:0] port0Pins,
   input wire logic [7:0] sfrAddr,
   input wire logic sfrWrite,
   input wire logic sfrRead,
   input wire logic [7:0] sfrWdata,
   output logic [7:0] sfrRdata,
   input wire logic [1:0] vectorAck,
   output logic [1:0] irqPending,
   output logic timer5Priority,
   output logic timer4Priority,
   output logic smbus1Priority,
   output logic uart1Priority,
   output logic vbusLevelPriority
);
   import eic_pkg::*;

   logic [7:0] port0Sync1_r;
   logic [7:0] port0Sync2_r;
   logic [7:0] extIrqConfig_r;
   logic [7:0] extIrqConfig_nxt;
   logic [7:0] extPriorityTwo_r;
   logic [7:0] extPriorityTwo_nxt;
   logic [1:0] edgeSelect_r;
   logic [1:0] edgeSelect_nxt;
   logic [1:0] pending_r;
   logic [1:0] pending_nxt;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   logic [1:0] activeV;
   logic [1:0] edgeHitV;
   logic [1:0] polarityV;
   logic [EIC_SEL_W-1:0] pinSel [2];
   logic wrConfig;
   logic wrPrio;
   logic wrTcon;

   assign wrConfig = sfrWrite && (sfrAddr == EIC_ADDR_CONFIG);
   assign wrPrio = sfrWrite && (sfrAddr == EIC_ADDR_PRIO2);
   assign wrTcon = sfrWrite && (sfrAddr == EIC_ADDR_TIMER_CONTROL_REG);

   // Private two-stage sampler: pins are only observed, never driven
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         port0Sync1_r <= 8'h00;
         port0Sync2_r <= 8'h00;
      end else begin
         port0Sync1_r <= port0Pins;
         port0Sync2_r <= port0Sync1_r;
      end
   end

   assign pinSel[EIC_CH_A] = extIrqConfig_r[EIC_SEL_A_LSB +: EIC_SEL_W];
   assign pinSel[EIC_CH_B] = extIrqConfig_r[EIC_SEL_B_LSB +: EIC_SEL_W];
   assign polarityV[EIC_CH_A] = extIrqConfig_r[EIC_POL_A_BIT];
   assign polarityV[EIC_CH_B] = extIrqConfig_r[EIC_POL_B_BIT];

   generate
      for (genvar i = 0; i < 2; i++) begin : g_chan
         eic_chan_if chan ();
         assign chan.polarity = polarityV[i];
         assign chan.pinLevel = port0Sync2_r[pinSel[i]];
         assign activeV[i] = chan.activeNow;
         assign edgeHitV[i] = chan.edgeHit;
         eic_detect u_detect (
            .core_clk(core_clk),
            .reset_n(reset_n),
            .chan(chan.det)
         );
      end
   endgenerate

   always_comb begin
      extIrqConfig_nxt = wrConfig ? sfrWdata : extIrqConfig_r;
      extPriorityTwo_nxt = wrPrio ? (sfrWdata & EIC_PRIO2_WMASK) : extPriorityTwo_r;
      edgeSelect_nxt = edgeSelect_r;
      if (wrTcon) begin
         edgeSelect_nxt[EIC_CH_A] = sfrWdata[EIC_EDGE_A_BIT];
         edgeSelect_nxt[EIC_CH_B] = sfrWdata[EIC_EDGE_B_BIT];
      end
      for (int i = 0; i < 2; i++) begin
         if (edgeSelect_r[i]) begin
            pending_nxt[i] = pending_r[i];
            if (vectorAck[i]) begin
               pending_nxt[i] = 1'b0;
            end
            if (wrTcon) begin
               pending_nxt[i] = sfrWdata[(i == EIC_CH_A) ? EIC_PEND_A_BIT : EIC_PEND_B_BIT];
            end
            // Set wins over acknowledge or software clear
            if (edgeHitV[i]) begin
               pending_nxt[i] = 1'b1;
            end
         end else begin
            pending_nxt[i] = activeV[i];
         end
      end
      rdata_nxt = 8'h00;
      if (sfrRead) begin
         case (sfrAddr)
            EIC_ADDR_CONFIG: rdata_nxt = extIrqConfig_r;
            EIC_ADDR_PRIO2: rdata_nxt = extPriorityTwo_r;
            EIC_ADDR_TIMER_CONTROL_REG: begin
               rdata_nxt[EIC_EDGE_A_BIT] = edgeSelect_r[EIC_CH_A];
               rdata_nxt[EIC_PEND_A_BIT] = pending_r[EIC_CH_A];
               rdata_nxt[EIC_EDGE_B_BIT] = edgeSelect_r[EIC_CH_B];
               rdata_nxt[EIC_PEND_B_BIT] = pending_r[EIC_CH_B];
            end
            default: rdata_nxt = 8'h00;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         extIrqConfig_r <= EIC_CONFIG_RESET;
         extPriorityTwo_r <= EIC_PRIO2_RESET;
         edgeSelect_r <= 2'h0;
         pending_r <= 2'h0;
         rdata_r <= 8'h00;
      end else begin
         extIrqConfig_r <= extIrqConfig_nxt;
         extPriorityTwo_r <= extPriorityTwo_nxt;
         edgeSelect_r <= edgeSelect_nxt;
         pending_r <= pending_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign sfrRdata = rdata_r;
   assign irqPending = pending_r;
   assign timer5Priority = extPriorityTwo_r[EIC_PRIO_TIMER5];
   assign timer4Priority = extPriorityTwo_r[EIC_PRIO_TIMER4];
   assign smbus1Priority = extPriorityTwo_r[EIC_PRIO_SMBUS1];
   assign uart1Priority = extPriorityTwo_r[EIC_PRIO_UART1];
   assign vbusLevelPriority = extPriorityTwo_r[EIC_PRIO_VBUS];

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   chk_prio_upper_zero: assert property (wrPrio |=> extPriorityTwo_r[7:6] == 2'h0)
      else $error("Priority upper bits not zero");
   chk_prio_out_map: assert property (wrPrio |=> timer5Priority == $past(sfrWdata[5]) && vbusLevelPriority == $past(sfrWdata[0]))
      else $error("Priority output does not match write");
   chk_pol_active_a: assert property (activeV[0] == (port0Sync2_r[pinSel[0]] == extIrqConfig_r[EIC_POL_A_BIT]))
      else $error("Input A active level wrong");
   chk_pol_active_b: assert property (activeV[1] == (port0Sync2_r[pinSel[1]] == extIrqConfig_r[EIC_POL_B_BIT]))
      else $error("Input B active level wrong");
   chk_b_pin_route: assert property (g_chan[1].chan.pinLevel == port0Sync2_r[extIrqConfig_r[EIC_SEL_B_LSB +: EIC_SEL_W]])
      else $error("Input B routed from wrong pin");
   chk_a_pin_route: assert property (g_chan[0].chan.pinLevel == port0Sync2_r[extIrqConfig_r[EIC_SEL_A_LSB +: EIC_SEL_W]])
      else $error("Input A routed from wrong pin");
   chk_config_write: assert property (wrConfig |=> extIrqConfig_r == $past(sfrWdata))
      else $error("Config write did not land");
   // First stage is only checked once a full clock has passed out of reset
   chk_sync_first_stage: assert property ($past(reset_n) |-> port0Sync1_r == $past(port0Pins))
      else $error("Pin sampler first stage wrong");
   chk_sync_two_stage: assert property (port0Sync2_r == $past(port0Sync1_r))
      else $error("Pin sampler latency wrong");
   chk_edge_set_flag: assert property (edgeSelect_r[0] && edgeHitV[0] |=> pending_r[0])
      else $error("Edge did not set pending A");
   chk_edge_set_b: assert property (edgeSelect_r[1] && edgeHitV[1] |=> pending_r[1])
      else $error("Edge did not set pending B");
   chk_ack_clear_a: assert property (edgeSelect_r[0] && vectorAck[0] && !edgeHitV[0] && !wrTcon |=> !pending_r[0])
      else $error("Vector did not clear pending A");
   chk_ack_clear_flag: assert property (edgeSelect_r[1] && vectorAck[1] && !edgeHitV[1] && !wrTcon |=> !pending_r[1])
      else $error("Vector did not clear pending B");
   chk_level_follow_a: assert property (!edgeSelect_r[0] |=> pending_r[0] == $past(activeV[0]))
      else $error("Level pending A does not follow input");
   chk_level_follow_b: assert property (!edgeSelect_r[1] |=> pending_r[1] == $past(activeV[1]))
      else $error("Level pending B does not follow input");
   chk_timer_control_reg_read_a: assert property (sfrRead && sfrAddr == EIC_ADDR_TIMER_CONTROL_REG |=> sfrRdata[EIC_PEND_A_BIT] == $past(pending_r[0]))
      else $error("Pending A not at bit 1");
   chk_timer_control_reg_read_map: assert property (sfrRead && sfrAddr == EIC_ADDR_TIMER_CONTROL_REG |=> sfrRdata[3] == $past(pending_r[1]))
      else $error("Pending B not at bit 3");
endmodule

// ### verification/eic_irq_source.sv
module eic_irq_source (
   input wire logic [7:0] noise,
   input wire logic [2:0] pinSel,
   input wire logic activeHigh,
   input wire logic request,
   output logic [7:0] pins
);
   timeunit 1ns;
   timeprecision 1ns;
   // Other pins carry unrelated traffic; the request is held until the bench drops it
   always_comb begin
      pins = noise;
      pins[pinSel] = request ? activeHigh : ~activeHigh;
   end
endmodule

// ### verification/external_interrupt_config_test.sv
module external_interrupt_config_test;
   timeunit 1ns;
   timeprecision 1ns;
   import eic_pkg::*;
   logic core_clk, reset_n, sfrWrite, sfrRead, request, activeHigh, pa, pb, r;
   logic [7:0] port0Pins, sfrAddr, sfrWdata, sfrRdata, noise, rd, v, n;
   logic [2:0] pinSel, sa, sb;
   logic [1:0] vectorAck, irqPending;
   logic [4:0] prio;
   int bad_count = 0;
   int checks_done = 0;
   eic_irq_source src (.noise(noise), .pinSel(pinSel), .activeHigh(activeHigh), .request(request),
      .pins(port0Pins));
   eic_top dut (.core_clk(core_clk), .reset_n(reset_n), .port0Pins(port0Pins), .sfrAddr(sfrAddr),
      .sfrWrite(sfrWrite), .sfrRead(sfrRead), .sfrWdata(sfrWdata), .sfrRdata(sfrRdata),
      .vectorAck(vectorAck), .irqPending(irqPending), .timer5Priority(prio[4]), .timer4Priority(prio[3]),
      .smbus1Priority(prio[2]), .uart1Priority(prio[1]), .vbusLevelPriority(prio[0]));
   task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(posedge core_clk);
      sfrAddr <= a;
      sfrWdata <= d;
      sfrWrite <= 1'b1;
      @(posedge core_clk);
      sfrWrite <= 1'b0;
   endtask
   task automatic rd8(logic [7:0] a, output logic [7:0] d);
      @(posedge core_clk);
      sfrAddr <= a;
      sfrRead <= 1'b1;
      @(posedge core_clk);
      sfrRead <= 1'b0;
      #1 d = sfrRdata;
   endtask
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   initial begin
      {reset_n, sfrWrite, sfrRead, sfrAddr, sfrWdata, vectorAck, noise, activeHigh, request} = '0;
      pinSel = 3'h1;
      void'($urandom(74228));
      repeat (8) @(posedge core_clk);
      reset_n <= 1'b1;
      rd8(EIC_ADDR_CONFIG, rd);
      chk("config", rd, EIC_CONFIG_RESET);
      rd8(EIC_ADDR_PRIO2, rd);
      chk("prio", rd, 8'h00);
      rd8(8'h55, rd);
      chk("unmapped", rd, 8'h00);
      $display("reset test done");
      for (int i = 0; i < 8; i++) begin
         v = (i == 0) ? 8'hff : 8'($urandom);
         wr(EIC_ADDR_PRIO2, v);
         rd8(EIC_ADDR_PRIO2, rd);
         chk("prio", rd, v & 8'h3f);
         chk("prio pins", {3'h0, prio}, {3'h0, v[5:3], v[1:0]});
      end
      $display("priority test done");
      for (int i = 0; i < 12; i++) begin
         {sa, pa, pb, r, n} = {3'($urandom), 3'($urandom), 8'($urandom)};
         sb = sa ^ 3'(1 + $urandom % 7);
         pinSel <= sa;
         activeHigh <= pa;
         wr(EIC_ADDR_CONFIG, {pb, sb, pa, sa});
         wr(EIC_ADDR_TIMER_CONTROL_REG, 8'h00);
         rd8(EIC_ADDR_CONFIG, rd);
         chk("config", rd, {pb, sb, pa, sa});
         @(posedge core_clk);
         noise <= n;
         request <= r;
         repeat (4) @(posedge core_clk);
         #1 chk("level", {6'h0, irqPending}, {6'h0, n[sb] == pb, r});
      end
      $display("level test done");
      pinSel <= 3'h3;
      activeHigh <= 1'b1;
      request <= 1'b0;
      noise <= 8'h00;
      wr(EIC_ADDR_CONFIG, 8'heb);
      wr(EIC_ADDR_TIMER_CONTROL_REG, 8'h05);
      repeat (4) @(posedge core_clk);
      wr(EIC_ADDR_TIMER_CONTROL_REG, 8'h05);
      rd8(EIC_ADDR_TIMER_CONTROL_REG, rd);
      chk("timer_control_reg", rd, 8'h05);
      @(posedge core_clk);
      request <= 1'b1;
      for (int k = 0; k <= 8; k++) begin
         @(posedge core_clk);
         #1 if (irqPending[0] === 1'b1) break;
         if (k == 8) begin
            chk("edge pending", {7'h0, irqPending[0]}, 8'h01);
            conclude();
         end
      end
      @(posedge core_clk);
      request <= 1'b0;
      repeat (5) @(posedge core_clk);
      rd8(EIC_ADDR_TIMER_CONTROL_REG, rd);
      chk("timer_control_reg", rd, 8'h07);
      @(posedge core_clk);
      vectorAck <= 2'b01;
      @(posedge core_clk);
      vectorAck <= 2'b00;
      repeat (3) @(posedge core_clk);
      #1 chk("edge ack", {6'h0, irqPending}, 8'h00);
      @(posedge core_clk);
      noise <= 8'h40;
      repeat (4) @(posedge core_clk);
      #1 chk("edge b", {6'h0, irqPending}, 8'h02);
      @(posedge core_clk);
      noise <= 8'h00;
      vectorAck <= 2'b10;
      @(posedge core_clk);
      vectorAck <= 2'b00;
      repeat (3) @(posedge core_clk);
      #1 chk("edge ack b", {6'h0, irqPending}, 8'h00);
      $display("edge test done");
      conclude();
   end
endmodule
